// [src/bmc_top.sv]
`include "bmc_cfg.svh"
module bmc_top
   import bmc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [`BMC_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // unmapped access flags: shared, debug, dma, cpu data, cpu instr
   input wire logic [`BMC_N_INIT-1:0] unmapped_i,
   input wire logic debug_mode_i,
   // cpu data ram access
   input wire logic ram_req_i,
   output logic ram_ready_o,
   // matrix outputs
   output logic [`BMC_N_INIT-1:0] bus_err_o,
   output logic [2:0] arb_mode_o,
   output logic irq_o
);
   logic [31:0] cfg_q;
   logic [`BMC_N_INIT-1:0] stat_q;
   logic [`BMC_N_INIT-1:0] mask_q;
   logic [`BMC_N_INIT-1:0] en_w;
   logic [`BMC_N_INIT-1:0] blk_w;
   logic [`BMC_N_INIT-1:0] err_w;
   logic cfg_wr;
   logic stat_wr;

   assign cfg_wr = wr_i && (addr_i == `BMC_OFF_CFG);
   assign stat_wr = wr_i && (addr_i == `BMC_OFF_STAT);
   assign en_w = cfg_q[`BMC_BIT_SHARED:`BMC_BIT_CINSTR];
   // only cpu ports are blocked in debug mode
   assign blk_w = {3'h0, debug_mode_i, debug_mode_i};

   // unimplemented bits masked away on write
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cfg_q <= `BMC_CFG_RST;
      end else if (cfg_wr) begin
         cfg_q <= wdata_i & `BMC_CFG_MASK;
      end
   end

   // mask register sits in the upper half of the status word
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         mask_q <= 5'h00;
      end else if (stat_wr) begin
         mask_q <= wdata_i[16+`BMC_N_INIT-1:16];
      end
   end

   // set beats clear so an error in the clear cycle is kept
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         stat_q <= 5'h00;
      end else begin
         stat_q <= (stat_q & ~(stat_wr ? wdata_i[`BMC_N_INIT-1:0] : 5'h00)) | err_w;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `BMC_N_INIT; gi++) begin : g_err
         bmc_err_gate u_gate (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .en_i(en_w[gi]),
            .block_i(blk_w[gi]),
            .unmapped_i(unmapped_i[gi]),
            .err_o(err_w[gi])
         );
      end
   endgenerate
   assign bus_err_o = err_w;

   bmc_ram_wait u_wait (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .wait_en_i(cfg_q[`BMC_BIT_WAIT]),
      .req_i(ram_req_i),
      .ready_o(ram_ready_o)
   );

   // reserved codes pass through unchanged; software must avoid them
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         arb_mode_o <= BMC_ARB_M1;
      end else begin
         arb_mode_o <= cfg_q[2:0];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_q & mask_q);
      end
   end

   // size registers have no write path at all
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            `BMC_OFF_CFG: rdata_o <= cfg_q;
            `BMC_OFF_PFSZ: rdata_o <= `BMC_PFSZ_VAL;
            `BMC_OFF_BOOTSZ: rdata_o <= `BMC_BOOTSZ_VAL;
            `BMC_OFF_STAT: rdata_o <= {11'h000, mask_q, 11'h000, stat_q};
            default: rdata_o <= 32'h00000000;
         endcase
      end else begin
         rdata_o <= 32'h00000000;
      end
   end

   property p_cfg_mask;
      @(posedge core_clk_i) disable iff (!nrst_i)
      cfg_wr |=> (cfg_q == ($past(wdata_i) & `BMC_CFG_MASK));
   endproperty
   a_cfg_mask: assert property (p_cfg_mask) else $error("config write mask wrong");

   property p_shared;
      @(posedge core_clk_i) disable iff (!nrst_i)
      unmapped_i[4] |=> (bus_err_o[4] == $past(cfg_q[`BMC_BIT_SHARED]));
   endproperty
   a_shared: assert property (p_shared) else $error("shared bus error gate wrong");

   property p_debug;
      @(posedge core_clk_i) disable iff (!nrst_i)
      unmapped_i[3] |=> (bus_err_o[3] == $past(cfg_q[`BMC_BIT_DEBUG]));
   endproperty
   a_debug: assert property (p_debug) else $error("debug unit error gate wrong");

   property p_dma;
      @(posedge core_clk_i) disable iff (!nrst_i)
      unmapped_i[2] |=> (bus_err_o[2] == $past(cfg_q[`BMC_BIT_DMA]));
   endproperty
   a_dma: assert property (p_dma) else $error("dma error gate wrong");

   property p_cdata;
      @(posedge core_clk_i) disable iff (!nrst_i)
      debug_mode_i |=> !bus_err_o[1];
   endproperty
   a_cdata: assert property (p_cdata) else $error("cpu data error in debug mode");

   property p_cinstr;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (unmapped_i[0] && !debug_mode_i) |=> (bus_err_o[0] == $past(cfg_q[`BMC_BIT_CINSTR]));
   endproperty
   a_cinstr: assert property (p_cinstr) else $error("cpu fetch error gate wrong");

   property p_wait;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (ram_req_i && cfg_q[`BMC_BIT_WAIT] && !ram_ready_o && u_wait.state_q == BMC_WS_IDLE)
         |=> !ram_ready_o ##1 ram_ready_o;
   endproperty
   a_wait: assert property (p_wait) else $error("ram setup wait missing");

   property p_sizes;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (rd_i && addr_i == `BMC_OFF_BOOTSZ) |=> (rdata_o == `BMC_BOOTSZ_VAL);
   endproperty
   a_sizes: assert property (p_sizes) else $error("boot size read wrong");

   property p_arb;
      @(posedge core_clk_i) disable iff (!nrst_i)
      $changed(cfg_q[2:0]) |=> (arb_mode_o == $past(cfg_q[2:0]));
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration mode not followed");

   property p_cdata_en;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (unmapped_i[1] && !debug_mode_i)
         |=> (bus_err_o[1] == $past(cfg_q[`BMC_BIT_CDATA]));
   endproperty
   a_cdata_en: assert property (p_cdata_en) else $error("cpu data error gate wrong");

   property p_cinstr_dbg;
      @(posedge core_clk_i) disable iff (!nrst_i)
      debug_mode_i
         |=> !bus_err_o[0];
   endproperty
   a_cinstr_dbg: assert property (p_cinstr_dbg) else $error("cpu fetch error in debug mode");

   property p_err_idle;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (unmapped_i == 5'h00)
         |=> (bus_err_o == 5'h00);
   endproperty
   a_err_idle: assert property (p_err_idle) else $error("bus error without unmapped access");

   property p_nowait;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (ram_req_i && !cfg_q[`BMC_BIT_WAIT] && u_wait.state_q == BMC_WS_IDLE)
         |=> ram_ready_o;
   endproperty
   a_nowait: assert property (p_nowait) else $error("ram access delayed without wait");

   // a request during setup is dropped, so setup always lasts exactly one cycle
   property p_wait_ignore;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (u_wait.state_q == BMC_WS_SETUP)
         |=> (u_wait.state_q == BMC_WS_IDLE);
   endproperty
   a_wait_ignore: assert property (p_wait_ignore) else $error("setup wait longer than one cycle");

   property p_pfsz;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (rd_i && addr_i == `BMC_OFF_PFSZ)
         |=> (rdata_o == `BMC_PFSZ_VAL);
   endproperty
   a_pfsz: assert property (p_pfsz) else $error("program flash size read wrong");

   property p_cfg_read;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (rd_i && addr_i == `BMC_OFF_CFG)
         |=> (rdata_o == $past(cfg_q));
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

   property p_cfg_unimpl;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (cfg_q & ~`BMC_CFG_MASK) == 32'h00000000;
   endproperty
   a_cfg_unimpl: assert property (p_cfg_unimpl) else $error("unimplemented config bit set");

   property p_cfg_hold;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !cfg_wr
         |=> $stable(cfg_q);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

   property p_size_wr;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (wr_i && (addr_i == `BMC_OFF_PFSZ || addr_i == `BMC_OFF_BOOTSZ))
         |=> ($stable(cfg_q) && $stable(mask_q));
   endproperty
   a_size_wr: assert property (p_size_wr) else $error("size register write had an effect");

   property p_rd_idle;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !rd_i
         |=> (rdata_o == 32'h00000000);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

   property p_rd_unmapped;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (rd_i && addr_i[1:0] != 2'h0)
         |=> (rdata_o == 32'h00000000);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped offset read not zero");

   property p_stat_set;
      @(posedge core_clk_i) disable iff (!nrst_i)
      1'b1
         |=> ((stat_q & $past(bus_err_o)) == $past(bus_err_o));
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("error did not set status");

   property p_stat_clear;
      @(posedge core_clk_i) disable iff (!nrst_i)
      stat_wr
         |=> ((stat_q & $past(wdata_i[`BMC_N_INIT-1:0]) & ~$past(bus_err_o)) == 5'h00);
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by write");

   property p_stat_hold;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (!stat_wr && bus_err_o == 5'h00)
         |=> $stable(stat_q);
   endproperty
   a_stat_hold: assert property (p_stat_hold) else $error("status changed without cause");

   property p_mask_keep;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !stat_wr
         |=> $stable(mask_q);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("mask changed without write");

   property p_irq;
      @(posedge core_clk_i) disable iff (!nrst_i)
      1'b1
         |=> (irq_o == |($past(stat_q) & $past(mask_q)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

   property p_arb_follow;
      @(posedge core_clk_i) disable iff (!nrst_i)
      1'b1
         |=> (arb_mode_o == $past(cfg_q[2:0]));
   endproperty
   a_arb_follow: assert property (p_arb_follow) else $error("arbitration output lags config");

   // reset checks run without disable so the reset values themselves are seen
   property p_rst_cfg;
      @(posedge core_clk_i)
      !nrst_i
         |=> (cfg_q == `BMC_CFG_RST && stat_q == 5'h00 && mask_q == 5'h00);
   endproperty
   a_rst_cfg: assert property (p_rst_cfg) else $error("register reset value wrong");

   property p_rst_out;
      @(posedge core_clk_i)
      !nrst_i
         |=> (rdata_o == 32'h00000000 && bus_err_o == 5'h00 && !ram_ready_o && !irq_o && arb_mode_o == BMC_ARB_M1);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("output reset value wrong");

   c_wr: cover property (@(posedge core_clk_i) disable iff (!nrst_i) cfg_wr);
   c_err: cover property (@(posedge core_clk_i) disable iff (!nrst_i) |bus_err_o);
   c_irq: cover property (@(posedge core_clk_i) disable iff (!nrst_i) irq_o);
   c_wait: cover property (@(posedge core_clk_i) disable iff (!nrst_i) u_wait.state_q == BMC_WS_SETUP);
   c_ram: cover property (@(posedge core_clk_i) disable iff (!nrst_i) ram_ready_o);
endmodule // bmc_top

// [shared/bmc_cfg.svh]
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH
// Notes on behaviour
// - shared bus unmapped access faults only while shared_bus_err_en is set
// - debug unit unmapped access faults only while debug_unit_err_en is set
// - dma unmapped access faults only while dma_err_en is set
// - cpu data unmapped faults need cpu_data_err_en and no debug mode
// - cpu fetch unmapped faults need cpu_instr_err_en and no debug mode
// - ram_setup_wait set adds one setup wait on cpu data ram access
// - arbitration_select codes 000, 001, 010 pick modes 0, 1, 2; reset is 1
// - unimplemented configuration bits read zero and ignore writes
// - program flash size reads a fixed byte count, one of five sizes
// - boot flash size register is 32 bits, all read only
// - boot flash size reads 0x00000C00, three kilobytes
`define BMC_ADDR_W 4
`define BMC_OFF_CFG 4'h0
`define BMC_OFF_PFSZ 4'h4
`define BMC_OFF_BOOTSZ 4'h8
`define BMC_OFF_STAT 4'hC
`define BMC_CFG_MASK 32'h001F0047
`define BMC_CFG_RST 32'h001F0041
`define BMC_BIT_SHARED 20
`define BMC_BIT_DEBUG 19
`define BMC_BIT_DMA 18
`define BMC_BIT_CDATA 17
`define BMC_BIT_CINSTR 16
`define BMC_BIT_WAIT 6
`define BMC_PFSZ_VAL 32'h00040000
`define BMC_BOOTSZ_VAL 32'h00000C00
`define BMC_N_INIT 5
`endif

// [shared/bmc_pkg.sv]
package bmc_pkg;
   typedef enum logic [2:0] {
      BMC_ARB_M0 = 3'h0,
      BMC_ARB_M1 = 3'h1,
      BMC_ARB_M2 = 3'h2
   } bmc_arb_e;
   typedef enum logic [0:0] {
      BMC_WS_IDLE = 1'b0,
      BMC_WS_SETUP = 1'b1
   } bmc_ws_e;
endpackage

// [src/bmc_err_gate.sv]
// one initiator's bus error gate: pulse out when an unmapped access is enabled and not blocked
module bmc_err_gate (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic en_i,
   input wire logic block_i,
   input wire logic unmapped_i,
   // result
   output logic err_o
);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         err_o <= 1'b0;
      end else begin
         err_o <= unmapped_i & en_i & ~block_i;
      end
   end
endmodule // bmc_err_gate

// [src/bmc_ram_wait.sv]
// address setup wait for cpu data ram accesses
module bmc_ram_wait
   import bmc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic wait_en_i,
   input wire logic req_i,
   // result
   output logic ready_o
);
   bmc_ws_e state_q;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state_q <= BMC_WS_IDLE;
      end else begin
         case (state_q)
            BMC_WS_IDLE: if (req_i && wait_en_i) state_q <= BMC_WS_SETUP;
            BMC_WS_SETUP: state_q <= BMC_WS_IDLE;
            default: state_q <= BMC_WS_IDLE;
         endcase
      end
   end
   // ready comes from a flop so it is one cycle after the sampled request, or two cycles with the setup wait enabled
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= (req_i && !wait_en_i && state_q == BMC_WS_IDLE) || (state_q == BMC_WS_SETUP);
      end
   end
endmodule // bmc_ram_wait

// [sim/bmc_init_model.sv]
`include "bmc_cfg.svh"
module bmc_init_model (
   // clock
   input wire logic core_clk_i,
   // towards the matrix
   output logic [`BMC_N_INIT-1:0] unmapped_o,
   output logic debug_mode_o,
   output logic ram_req_o,
   input wire logic ram_ready_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      unmapped_o = '0;
      debug_mode_o = 1'b0;
      ram_req_o = 1'b0;
   end
   // one unmapped access by initiator k, seen at exactly one edge
   task automatic hit(input int k, input logic dbg);
      @(posedge core_clk_i);
      unmapped_o <= `BMC_N_INIT'(1) << k;
      debug_mode_o <= dbg;
      @(posedge core_clk_i);
      unmapped_o <= '0;
      debug_mode_o <= 1'b0;
   endtask
   // single outstanding ram access; n is edges to ready, 0 if none in 8
   task automatic ram(output int n);
      n = 0;
      @(posedge core_clk_i);
      ram_req_o <= 1'b1;
      @(posedge core_clk_i);
      ram_req_o <= 1'b0;
      for (int i = 1; i <= 8 && n == 0; i++) begin
         #1;
         if (ram_ready_i === 1'b1)
            n = i;
         else
            @(posedge core_clk_i);
      end
   endtask
endmodule // bmc_init_model

// [sim/tb_bus_matrix_config.sv]
`include "bmc_cfg.svh"
module tb_bus_matrix_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [`BMC_ADDR_W-1:0] addr_i = '0;
   logic [31:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [`BMC_N_INIT-1:0] unmapped_i;
   logic [`BMC_N_INIT-1:0] bus_err_o;
   logic debug_mode_i;
   logic ram_req_i;
   logic ram_ready_o;
   logic irq_o;
   logic [2:0] arb_mode_o;
   int errors = 0;
   int n_compared = 0;
   int n;
   initial forever #4 core_clk_i = ~core_clk_i;
   bmc_top u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .unmapped_i(unmapped_i), .debug_mode_i(debug_mode_i),
      .ram_req_i(ram_req_i), .ram_ready_o(ram_ready_o), .bus_err_o(bus_err_o), .arb_mode_o(arb_mode_o),
      .irq_o(irq_o));
   bmc_init_model u_init (.core_clk_i(core_clk_i), .unmapped_o(unmapped_i), .debug_mode_o(debug_mode_i),
      .ram_req_o(ram_req_i), .ram_ready_i(ram_ready_o));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp, "read");
   endtask
   // error pulse checked one cycle after the access edge
   task automatic err(input int k, input logic dbg, input logic [4:0] exp);
      u_init.hit(k, dbg);
      #1;
      chk(32'(bus_err_o), 32'(exp), "bus error");
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      #1;
      chk(32'(arb_mode_o), 32'h1, "arb reset");
      rd(`BMC_OFF_CFG, 32'h001F0041);
      rd(`BMC_OFF_PFSZ, 32'h00040000);
      rd(`BMC_OFF_BOOTSZ, 32'h00000C00);
      wr(`BMC_OFF_PFSZ, 32'hFFFFFFFF);
      wr(`BMC_OFF_BOOTSZ, 32'h00000000);
      rd(`BMC_OFF_PFSZ, 32'h00040000);
      rd(`BMC_OFF_BOOTSZ, 32'h00000C00);
      rd(4'h2, 32'h00000000);
      wr(`BMC_OFF_CFG, 32'hFFE0FFBA);
      rd(`BMC_OFF_CFG, 32'h00000002);
      $display("test registers done");
      for (int k = 0; k < 5; k++)
         err(k, 1'b0, 5'h00);
      for (int c = 0; c < 3; c++) begin
         wr(`BMC_OFF_CFG, 32'h001F0040 | c);
         @(posedge core_clk_i);
         #1;
         chk(32'(arb_mode_o), 32'(c), "arb mode");
      end
      u_init.ram(n);
      chk(n, 2, "setup wait");
      wr(`BMC_OFF_CFG, 32'h001F0002);
      u_init.ram(n);
      chk(n, 1, "no wait");
      $display("test arbitration and wait done");
      wr(`BMC_OFF_STAT, 32'h001F001F);
      for (int k = 0; k < 5; k++) begin
         err(k, 1'b0, 5'(1 << k));
         // status lands one edge after the error pulse, irq one edge later
         @(posedge core_clk_i);
         @(posedge core_clk_i);
         #1;
         chk(32'(irq_o), 32'h1, "irq set");
         wr(`BMC_OFF_STAT, 32'h001F001F);
         @(posedge core_clk_i);
         #1;
         chk(32'(irq_o), 32'h0, "irq clear");
      end
      for (int k = 0; k < 5; k++)
         err(k, 1'b1, (k < 2) ? 5'h00 : 5'(1 << k));
      wr(`BMC_OFF_STAT, 32'h0000001F);
      err(2, 1'b0, 5'h04);
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      #1;
      chk(32'(irq_o), 32'h0, "irq masked");
      rd(`BMC_OFF_STAT, 32'h00000004);
      wr(`BMC_OFF_STAT, 32'h00000004);
      rd(`BMC_OFF_STAT, 32'h00000000);
      $display("test bus errors done");
      wrap_up();
   end
endmodule // tb_bus_matrix_config
